// ==== hw/flash_ctl.sv ====
// What this block does
// - Reissue full aborted program or erase sequence after wake-up.
// - Issue Read Array before array reads after operations.
// - Write only with write and select both low.
// - Honour wake-to-read and wake-to-write delays.
`include "flash_ctl_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_ctl
   import flash_ctl_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic [20:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic pwr_fail,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic [7:0] rsp_status,
   output logic rsp_err,
   output logic [20:0] flash_addr,
   output logic [7:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_rp_n,
   input wire logic flash_ready_busy_out
);

   localparam logic [7:0] WP_CYC = 8'(`T_WP_CYC);
   localparam logic [7:0] ACC_CYC = 8'(`T_ACC_CYC);
   localparam logic [7:0] SETTLE_CYC = 8'(`T_SETTLE_CYC);
   localparam logic [7:0] WAKE_RD_CYC = 8'(`T_WAKE_RD_CYC);
   localparam logic [7:0] WAKE_WR_CYC = 8'(`T_WAKE_WR_CYC);

   state_t state_r;
   op_t op_r;
   logic [2:0] step_r;
   logic [7:0] cnt_r;
   logic [7:0] wdata_r;
   logic [7:0] status_r;
   logic need_ra_r;
   logic replay_r;
   logic sleep_hold_r;
   logic [7:0] wake_cnt_r;
   logic ry_s1_r, ry_s2_r, ry_s3_r, ry_r;
   logic [7:0] dq_s1_r, dq_s2_r, dq_s3_r;
   kind_t mk;
   logic [7:0] md;
   logic alters;

   // Ready line is always driven, so it is sampled regardless of select
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ry_s1_r <= 1'b1;
         ry_s2_r <= 1'b1;
         ry_s3_r <= 1'b1;
         ry_r <= 1'b1;
      end else begin
         ry_s1_r <= flash_ready_busy_out;
         ry_s2_r <= ry_s1_r;
         ry_s3_r <= ry_s2_r;
         if (ry_s2_r == ry_s3_r) begin
            ry_r <= ry_s3_r;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dq_s1_r <= 8'h00;
         dq_s2_r <= 8'h00;
         dq_s3_r <= 8'h00;
      end else begin
         dq_s1_r <= flash_dq_in;
         dq_s2_r <= dq_s1_r;
         dq_s3_r <= dq_s2_r;
      end
   end

   // Counts time since the last rise of reset_powerdown_n
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wake_cnt_r <= 8'h00;
      end else if (!flash_rp_n) begin
         wake_cnt_r <= 8'h00;
      end else if (wake_cnt_r != 8'hFF) begin
         wake_cnt_r <= wake_cnt_r + 8'h01;
      end
   end

   assign alters = (op_r == OP_PROG) || (op_r == OP_ERASE);

   // Micro-step table per operation
   always_comb begin
      mk = K_END;
      md = `FC_READ_ARRAY;
      case (op_r)
         OP_READ: begin
            case (step_r)
               3'h0: begin mk = K_WR; md = `FC_READ_ARRAY; end
               3'h1: mk = K_RD;
               default: mk = K_END;
            endcase
         end
         OP_PROG, OP_ERASE: begin
            case (step_r)
               3'h0: begin mk = K_WR; md = (op_r == OP_PROG) ? `FC_BYTE_WRITE : `FC_ERASE_SETUP; end
               3'h1: begin mk = K_WR; md = (op_r == OP_PROG) ? wdata_r : `FC_ERASE_CONFIRM; end
               3'h2: mk = K_BUSY;
               3'h3: begin mk = K_WR; md = `FC_READ_STATUS; end
               3'h4: mk = K_RD;
               3'h5: begin mk = K_WR; md = `FC_CLEAR_STATUS; end
               default: mk = K_END;
            endcase
         end
         OP_STATUS: begin
            case (step_r)
               3'h0: begin mk = K_WR; md = `FC_READ_STATUS; end
               3'h1: mk = K_RD;
               default: mk = K_END;
            endcase
         end
         default: mk = K_END;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_SLEEP;
         op_r <= OP_READ;
         step_r <= 3'h0;
         cnt_r <= 8'h00;
         wdata_r <= 8'h00;
         status_r <= 8'h00;
         need_ra_r <= 1'b0;
         replay_r <= 1'b0;
         sleep_hold_r <= 1'b0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_status <= 8'h00;
         rsp_err <= 1'b0;
         flash_addr <= 21'h000000;
         flash_dq_out <= 8'h00;
         flash_dq_oe <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_rp_n <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (pwr_fail && state_r != ST_SLEEP) begin
            // Power-down aborts any operation; device stays disabled meanwhile
            flash_rp_n <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            cmd_ready <= 1'b0;
            if (state_r != ST_IDLE && state_r != ST_WAKE && alters) begin
               replay_r <= 1'b1;
            end
            state_r <= ST_SLEEP;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  cmd_ready <= 1'b1;
                  if (cmd_valid && cmd_ready) begin
                     cmd_ready <= 1'b0;
                     op_r <= op_t'(cmd_op);
                     flash_addr <= cmd_addr;
                     wdata_r <= cmd_wdata;
                     if (op_t'(cmd_op) == OP_SLEEP) begin
                        sleep_hold_r <= 1'b1;
                        flash_rp_n <= 1'b0;
                        state_r <= ST_SLEEP;
                     end else if (op_t'(cmd_op) == OP_WAKE) begin
                        rsp_valid <= 1'b1;
                        rsp_err <= 1'b0;
                     end else begin
                        step_r <= (op_t'(cmd_op) == OP_READ && !need_ra_r) ? 3'h1 : 3'h0;
                        state_r <= ST_STEP;
                     end
                  end
               end
               ST_STEP: begin
                  case (mk)
                     K_WR: begin
                        // Writes wait out the wake-to-write delay
                        if (wake_cnt_r >= WAKE_WR_CYC) begin
                           flash_dq_out <= md;
                           flash_dq_oe <= 1'b1;
                           flash_ce_n <= 1'b0;
                           flash_we_n <= 1'b0;
                           cnt_r <= WP_CYC;
                           state_r <= ST_WRITE;
                        end
                     end
                     K_RD: begin
                        if (wake_cnt_r >= WAKE_RD_CYC) begin
                           flash_dq_oe <= 1'b0;
                           flash_ce_n <= 1'b0;
                           flash_oe_n <= 1'b0;
                           // Extra cycles cover the data synchroniser
                           cnt_r <= ACC_CYC + 8'h03;
                           state_r <= ST_READ;
                        end
                     end
                     K_BUSY: begin
                        cnt_r <= SETTLE_CYC;
                        state_r <= ST_BUSY;
                     end
                     default: begin
                        // Program, erase and status reads leave the latch out of read-array
                        need_ra_r <= (op_r != OP_READ);
                        replay_r <= 1'b0;
                        rsp_valid <= 1'b1;
                        rsp_status <= status_r;
                        rsp_err <= alters && (status_r[`SB_SUPPLY_LOW] || status_r[`SB_PROGRAM_ERR] ||
                                              status_r[`SB_ERASE_ERR]);
                        state_r <= ST_IDLE;
                     end
                  endcase
               end
               ST_WRITE: begin
                  if (cnt_r <= 8'h01) begin
                     // Strobe rises first so data and select hold past it
                     flash_we_n <= 1'b1;
                     state_r <= ST_WREC;
                  end else begin
                     cnt_r <= cnt_r - 8'h01;
                  end
               end
               ST_WREC: begin
                  flash_ce_n <= 1'b1;
                  flash_dq_oe <= 1'b0;
                  if (op_r == OP_READ) begin
                     need_ra_r <= 1'b0;
                  end
                  step_r <= step_r + 3'h1;
                  state_r <= ST_STEP;
               end
               ST_READ: begin
                  if (cnt_r > 8'h01) begin
                     cnt_r <= cnt_r - 8'h01;
                  end else if (dq_s2_r == dq_s3_r) begin
                     if (op_r == OP_READ) begin
                        rsp_data <= dq_s3_r;
                     end else begin
                        status_r <= dq_s3_r;
                        rsp_data <= dq_s3_r;
                     end
                     flash_ce_n <= 1'b1;
                     flash_oe_n <= 1'b1;
                     step_r <= step_r + 3'h1;
                     state_r <= ST_STEP;
                  end
               end
               ST_BUSY: begin
                  // Settle first so a late fall of the ready line is not missed
                  if (cnt_r != 8'h00) begin
                     cnt_r <= cnt_r - 8'h01;
                  end else if (ry_r) begin
                     step_r <= step_r + 3'h1;
                     state_r <= ST_STEP;
                  end
               end
               ST_SLEEP: begin
                  flash_rp_n <= 1'b0;
                  cmd_ready <= sleep_hold_r && !pwr_fail;
                  if (cmd_valid && cmd_ready && op_t'(cmd_op) == OP_WAKE) begin
                     sleep_hold_r <= 1'b0;
                     cmd_ready <= 1'b0;
                  end
                  if (!pwr_fail && !(sleep_hold_r && !(cmd_valid && cmd_ready && op_t'(cmd_op) == OP_WAKE))) begin
                     flash_rp_n <= 1'b1;
                     cmd_ready <= 1'b0;
                     state_r <= ST_WAKE;
                  end
               end
               ST_WAKE: begin
                  // Device returns in read-array with its flags cleared
                  need_ra_r <= 1'b0;
                  status_r <= 8'h00;
                  if (replay_r) begin
                     step_r <= 3'h0;
                     state_r <= ST_STEP;
                  end else begin
                     if (sleep_hold_r == 1'b0 && op_r == OP_SLEEP) begin
                        rsp_valid <= 1'b1;
                        rsp_err <= 1'b0;
                     end
                     state_r <= ST_IDLE;
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

endmodule // flash_ctl

`default_nettype wire

// ==== hw/flash_ctl_defs.svh ====
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH

// Clock rate of mclk in MHz
`define MCLK_MHZ 32'h14

// Bus timing in ns: write pulse, read access, busy settle after confirm
`define T_WP_NS 32'h46
`define T_ACC_NS 32'h78
`define T_SETTLE_NS 32'hC8
// Wake-up delays after reset_powerdown_n rises, in ns
`define T_WAKE_RD_NS 32'h3E8
`define T_WAKE_WR_NS 32'h3E8

// Least times round up to whole cycles
`define NS_TO_CYC(ns) (((ns) * `MCLK_MHZ + 32'h3E7) / 32'h3E8)
`define T_WP_CYC `NS_TO_CYC(`T_WP_NS)
`define T_ACC_CYC `NS_TO_CYC(`T_ACC_NS)
`define T_SETTLE_CYC `NS_TO_CYC(`T_SETTLE_NS)
`define T_WAKE_RD_CYC `NS_TO_CYC(`T_WAKE_RD_NS)
`define T_WAKE_WR_CYC `NS_TO_CYC(`T_WAKE_WR_NS)

// Command codes written to the flash command latch
`define FC_READ_ARRAY 8'hFF
`define FC_READ_STATUS 8'h70
`define FC_CLEAR_STATUS 8'h50
`define FC_BYTE_WRITE 8'h40
`define FC_ERASE_SETUP 8'h20
`define FC_ERASE_CONFIRM 8'hD0

// Status bit positions
`define SB_SUPPLY_LOW 3
`define SB_PROGRAM_ERR 4
`define SB_ERASE_ERR 5
`define SB_ENGINE_READY 7

`endif

// ==== hw/flash_ctl_pkg.sv ====
package flash_ctl_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_STEP = 3'h1,
      ST_WRITE = 3'h3,
      ST_WREC = 3'h2,
      ST_READ = 3'h6,
      ST_BUSY = 3'h7,
      ST_SLEEP = 3'h5,
      ST_WAKE = 3'h4
   } state_t;

   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_PROG = 3'h1,
      OP_ERASE = 3'h2,
      OP_STATUS = 3'h3,
      OP_SLEEP = 3'h4,
      OP_WAKE = 3'h5
   } op_t;

   typedef enum logic [1:0] {
      K_WR = 2'h0,
      K_RD = 2'h1,
      K_BUSY = 2'h2,
      K_END = 2'h3
   } kind_t;

endpackage

// ==== testbench/flash_ctl_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module flash_ctl_assertions (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic rsp_err,
   input wire logic pwr_fail,
   input wire logic flash_dq_oe,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_rp_n,
   input wire logic flash_ready_busy_out
);
   logic [5:0] wake_cnt_r;

   // Saturates so a long idle spell cannot wrap back under the wake limit
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) wake_cnt_r <= 6'h00;
      else if (!flash_rp_n) wake_cnt_r <= 6'h00;
      else if (wake_cnt_r != 6'h3F) wake_cnt_r <= wake_cnt_r + 6'h01;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   we_needs_ce_a: assert property (!flash_we_n |-> !flash_ce_n)
      else $error("write strobe without select");
   we_width_a: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
      else $error("write pulse width wrong");
   bus_turn_a: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
      else $error("read with host driving data");
   rp_quiet_a: assert property (!flash_rp_n |-> flash_ce_n && flash_oe_n && flash_we_n && !flash_dq_oe)
      else $error("pins active in power-down");
   fail_abort_a: assert property (pwr_fail |=> !flash_rp_n)
      else $error("power fail did not lower reset pin");
   busy_hold_a: assert property ((!flash_ready_busy_out) [*4] |-> flash_we_n)
      else $error("write while device busy");
   wake_gap_a: assert property (!flash_we_n |-> wake_cnt_r >= 6'h13)
      else $error("write too soon after wake");
   rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   take_drop_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready stayed after take");

   cover property (pwr_fail ##1 !flash_rp_n);
   cover property ($rose(flash_ready_busy_out) && flash_rp_n);
   cover property (rsp_valid && rsp_err);
endmodule // flash_ctl_assertions

bind flash_ctl flash_ctl_assertions i_flash_ctl_assertions (.*);

`default_nettype wire

// ==== testbench/flash_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_defs.svh"

module flash_dev_model (
   input wire logic mclk,
   input wire logic [20:0] flash_addr,
   input wire logic [7:0] flash_dq_out,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_rp_n,
   input wire logic vpp_bad,
   output logic [7:0] flash_dq_in,
   output logic flash_ready_busy_out
);
   logic [7:0] mem_r [16];
   logic [7:0] sr_r;
   logic [7:0] last_r = 8'h00;
   logic [1:0] mode_r;
   logic [3:0] pa_r;
   time busy_end = 0;

   initial for (int i = 0; i < 16; i++) mem_r[i] = 8'hFF;

   always @(posedge flash_we_n or negedge flash_rp_n) begin
      if (!flash_rp_n) begin
         mode_r <= 2'h0;
         sr_r <= 8'h00;
         // An abort leaves the byte half written
         if ($time < busy_end) mem_r[pa_r] <= 8'h00;
         busy_end <= 0;
      end else if (!flash_ce_n) begin
         if (mode_r == 2'h2) begin
            sr_r[4:3] <= {2{vpp_bad}};
            if (!vpp_bad) mem_r[flash_addr[3:0]] <= flash_dq_out;
            pa_r <= flash_addr[3:0];
            busy_end <= $time + 1500;
            mode_r <= 2'h1;
         end else if (mode_r == 2'h3) begin
            if (flash_dq_out == `FC_ERASE_CONFIRM) begin
               sr_r[5] <= vpp_bad;
               sr_r[3] <= vpp_bad;
               if (!vpp_bad) for (int i = 0; i < 16; i++) mem_r[i] <= 8'hFF;
               busy_end <= $time + 1500;
            end
            mode_r <= 2'h1;
         end else case (flash_dq_out)
            `FC_READ_ARRAY: mode_r <= 2'h0;
            `FC_READ_STATUS: mode_r <= 2'h1;
            `FC_CLEAR_STATUS: sr_r <= 8'h00;
            `FC_BYTE_WRITE: mode_r <= 2'h2;
            `FC_ERASE_SETUP: mode_r <= 2'h3;
            default: ;
         endcase
      end
   end

   always @(posedge mclk) flash_ready_busy_out <= !flash_rp_n || ($time >= busy_end);

   always @(posedge mclk) last_r <= flash_dq_in;

   // Released bus shows a changing pattern, never the last byte
   always_comb begin
      if (!flash_ce_n && !flash_oe_n && flash_rp_n)
         flash_dq_in = (mode_r == 2'h0) ? mem_r[flash_addr[3:0]] : (sr_r | {flash_ready_busy_out, 7'h00});
      else flash_dq_in = ~last_r;
   end
endmodule // flash_dev_model

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import flash_ctl_pkg::*;
   logic mclk, resetn, cmd_valid, pwr_fail, vpp_bad, cmd_ready, rsp_valid, rsp_err;
   logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_rp_n, flash_ready_busy_out;
   logic [2:0] cmd_op;
   logic [20:0] cmd_addr, flash_addr;
   logic [7:0] cmd_wdata, rsp_data, rsp_status, flash_dq_out, flash_dq_in;
   int errors = 0;
   int n_compared = 0;
   // Columns: op, address, write data, expected data or error flag
   logic [22:0] rows [8] = '{{3'h1, 4'h3, 8'h5A, 8'h00}, {3'h0, 4'h3, 8'h00, 8'h5A},
      {3'h1, 4'h4, 8'hA5, 8'h00}, {3'h0, 4'h4, 8'h00, 8'hA5}, {3'h3, 4'h0, 8'h00, 8'h80},
      {3'h2, 4'h0, 8'h00, 8'h00}, {3'h0, 4'h3, 8'h00, 8'hFF}, {3'h0, 4'h4, 8'h00, 8'hFF}};

   flash_ctl i_flash_ctl (.*);
   flash_dev_model i_flash_dev_model (.*);

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic do_cmd(input logic [2:0] op, input logic [20:0] a, input logic [7:0] d, input bit wait_rsp);
      int n;
      @(posedge mclk);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 200);
      cmd_valid <= 1'b0;
      if (wait_rsp) begin
         n = 0;
         do begin
            @(negedge mclk);
            n++;
         end while (rsp_valid !== 1'b1 && n < 3000);
         check({7'h00, rsp_valid}, 8'h01);
      end
   endtask

   task automatic pulse_fail;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (flash_ready_busy_out !== 1'b0 && n < 500);
      repeat (3) @(posedge mclk);
      pwr_fail <= 1'b1;
      repeat (5) @(posedge mclk);
      pwr_fail <= 1'b0;
   endtask

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial begin
      #3000000;
      errors++;
      give_verdict;
   end

   initial begin
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = 3'h0;
      cmd_addr = 21'h000000;
      cmd_wdata = 8'h00;
      pwr_fail = 1'b0;
      vpp_bad = 1'b0;
      repeat (6) @(posedge mclk);
      check({6'h00, flash_rp_n, flash_ce_n}, 8'h01);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         do_cmd(rows[i][22:20], {17'h00000, rows[i][19:16]}, rows[i][15:8], 1'b1);
         if (rows[i][22:20] inside {3'h1, 3'h2}) check({7'h00, rsp_err}, rows[i][7:0]);
         else check(rsp_data, rows[i][7:0]);
         $display("row %0d done", i);
      end
      @(posedge mclk);
      vpp_bad <= 1'b1;
      do_cmd(3'h1, 21'h000005, 8'h11, 1'b1);
      check(rsp_status & 8'h38, 8'h18);
      check({7'h00, rsp_err}, 8'h01);
      do_cmd(3'h2, 21'h000000, 8'h00, 1'b1);
      check(rsp_status & 8'h38, 8'h28);
      @(posedge mclk);
      vpp_bad <= 1'b0;
      $display("supply error test done");
      do_cmd(3'h4, 21'h000000, 8'h00, 1'b0);
      repeat (3) @(posedge mclk);
      check({7'h00, flash_rp_n}, 8'h00);
      check({7'h00, flash_ready_busy_out}, 8'h01);
      do_cmd(3'h5, 21'h000000, 8'h00, 1'b1);
      // A wake request while already awake answers at once
      do_cmd(3'h5, 21'h000000, 8'h00, 1'b1);
      check({7'h00, rsp_err}, 8'h00);
      do_cmd(3'h3, 21'h000000, 8'h00, 1'b1);
      check(rsp_data, 8'h80);
      $display("sleep test done");
      fork
         do_cmd(3'h1, 21'h000006, 8'h3C, 1'b1);
         pulse_fail;
      join
      do_cmd(3'h0, 21'h000006, 8'h00, 1'b1);
      check(rsp_data, 8'h3C);
      $display("abort test done");
      give_verdict;
   end
endmodule // testbench

`default_nettype wire
